// ==== verilog/sar_conv_dev.sv ====
/*
  Converter end: conversion sequencer on CLOCK and bit-serial readout on the
  host's burst read clock, with optional echoed clock.
  Assumes the host keeps the read clock still outside bursts, gives exactly
  sixteen rising edges per burst and starts no burst before the first bit
  is ready, so the result word is frozen whenever the read clock moves.
*/
`timescale 1ns/1ns
`default_nettype none

`include "sar_readout_cfg.svh"

module sar_conv_dev
  import conv_readout_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  sar_link_if.dev          link,
  input  wire logic [15:0] SAMPLE,
  input  wire logic        CNV_LVDS,
  output logic             BUSY,
  output logic [15:0]      RESULT
);

  conv_state_t state;
  logic [1:0]  cnv_meta;
  logic [1:0]  cnv_sync;
  logic        cnv_level;
  logic        cnv_prev;
  logic        cnv_rise;
  logic        snz_meta;
  logic        snz_sync;
  logic [7:0]  acq_cnt;
  logic [3:0]  step;
  word_t       held;
  word_t       code;
  word_t       trial;
  word_t       next_code;
  logic        mode_meta;
  logic        mode_sync;
  logic [3:0]  bit_idx;
  logic [14:0] shift;
  logic        data;
  logic        echo;

  // Start pins, both legs synchronised before use
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnv_meta <= 2'h0;
      cnv_sync <= 2'h0;
    end else begin
      cnv_meta <= {link.conv_start_n, link.conv_start_p};
      cnv_sync <= cnv_meta;
    end
  end

  // Differential format needs both legs apart; single-ended reads one leg
  assign cnv_level = CNV_LVDS ? (cnv_sync[0] & ~cnv_sync[1]) : cnv_sync[0];

  // Edge detector on the synchronised start level
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnv_prev <= 1'b0;
    end else begin
      cnv_prev <= cnv_level;
    end
  end

  assign cnv_rise = cnv_level & ~cnv_prev;

  // Snooze pin synchroniser
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      snz_meta <= 1'b0;
      snz_sync <= 1'b0;
    end else begin
      snz_meta <= link.snooze;
      snz_sync <= snz_meta;
    end
  end

  // One approximation step: try the current bit, keep it if not above
  assign trial     = code | (16'h0001 << step);
  assign next_code = (trial <= held) ? trial : code;

  // Conversion sequencer
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state   <= CV_ACQ;
      acq_cnt <= 8'(`ACQ_CYC - 1);
      step    <= `SAR_FIRST_STEP;
    end else begin
      case (state)
        CV_ACQ: begin
          // Sampling network settles; starts seen now are dropped
          if (acq_cnt == 8'h00) begin
            state <= CV_READY;
          end else begin
            acq_cnt <= acq_cnt - 8'h01;
          end
        end
        CV_READY: begin
          // Snoozed converter ignores start pulses
          if (cnv_rise && !snz_sync) begin
            state <= CV_CONVERT;
            step  <= `SAR_FIRST_STEP;
          end
        end
        CV_CONVERT: begin
          if (step == 4'h0) begin
            state   <= CV_ACQ;
            acq_cnt <= 8'(`ACQ_CYC - 1);
          end else begin
            step <= step - 4'h1;
          end
        end
        default: begin
          state <= CV_ACQ;
        end
      endcase
    end
  end

  // Sample and trial code; offset binary inside so the search is unsigned
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      held <= '0;
      code <= '0;
    end else if (state == CV_READY && cnv_rise && !snz_sync) begin
      held <= SAMPLE ^ `SIGN_FLIP;
      code <= '0;
    end else if (state == CV_CONVERT) begin
      code <= next_code;
    end
  end

  // Result word, refreshed at the end of every conversion
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      RESULT <= `RESULT_RESET;
    end else if (state == CV_CONVERT && step == 4'h0) begin
      RESULT <= next_code ^ `SIGN_FLIP;
    end
  end

  // Busy while approximating
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= (state == CV_READY && cnv_rise && !snz_sync) ||
              (state == CV_CONVERT && step != 4'h0);
    end
  end

  // Readout mode pin, synchronised on CLOCK so a change is settled before
  // the next burst; a read-clock sync would lose the first two echo bits.
  // The host moves the pin only while idle, so the echo flop sees it still.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
    end else begin
      mode_meta <= link.echo_mode;
      mode_sync <= mode_meta;
    end
  end

  // Bit counter; sixteen edges per burst bring it back to zero
  always_ff @(posedge link.read_clk_p or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_idx <= 4'h0;
    end else begin
      bit_idx <= bit_idx + 4'h1;
    end
  end

  // Shifter: the first edge of a burst loads the frozen result word, so
  // the readout carries the conversion just finished and nothing older
  always_ff @(posedge link.read_clk_p or negedge ARST_N) begin
    if (!ARST_N) begin
      data  <= 1'b0;
      shift <= '0;
    end else if (bit_idx == 4'h0) begin
      data  <= RESULT[`RESULT_MSB];
      shift <= RESULT[14:0];
    end else begin
      data  <= shift[14];
      shift <= {shift[13:0], 1'b0};
    end
  end

  // Echoed clock toggles once per bit; held still in self-clocked mode
  always_ff @(posedge link.read_clk_p or negedge ARST_N) begin
    if (!ARST_N) begin
      echo <= 1'b0;
    end else if (mode_sync) begin
      echo <= ~echo;
    end else begin
      echo <= 1'b0;
    end
  end

  // Differential output legs
  assign link.data_p = data;
  assign link.data_n = ~data;
  assign link.echo_p = echo;
  assign link.echo_n = ~echo;

endmodule : sar_conv_dev

`default_nettype wire

// ==== verilog/sar_readout_cfg.svh ====
/*
  Constants of the converter readout: word layout, reset values and timing.
  Assumes the including file runs its logic on the 125 MHz CLOCK.
*/
`ifndef SAR_READOUT_CFG_SVH
`define SAR_READOUT_CFG_SVH

// Word layout
`define RESULT_BITS      16
`define RESULT_MSB       15
`define SIGN_FLIP        16'h8000
`define RESULT_RESET     16'h0000
`define SAR_FIRST_STEP   4'hf

// Clock period of both CLOCK inputs
`define CLK_PERIOD_NS    8

// Least spacing of two starts, 5 million samples per second
`define CONV_PERIOD_NS   200
`define CONV_PERIOD_CYC  ((`CONV_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Start edge to first result bit available
`define FIRST_BIT_READY_NS  200
`define FIRST_BIT_READY_CYC ((`FIRST_BIT_READY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Width of the start pulse
`define CNV_HIGH_NS      16
`define CNV_HIGH_CYC     ((`CNV_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Acquisition time after each conversion
`define ACQ_NS           40
`define ACQ_CYC          ((`ACQ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Read clock half period and echo settling tail, in CLOCK cycles
`define READ_HALF_CYC    3
`define TAIL_CYC         4

`endif

// ==== verilog/conv_readout_pkg.sv ====
/*
  Types shared by both ends of the converter readout link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package conv_readout_pkg;

  // Conversion sequencer of the converter
  typedef enum logic [1:0] {CV_ACQ, CV_READY, CV_CONVERT} conv_state_t;

  // Sequencer of the capturing host
  typedef enum logic [2:0] {H_IDLE, H_START, H_WAIT, H_BURST, H_TAIL, H_PUSH} host_state_t;

  typedef logic [15:0] word_t;

endpackage : conv_readout_pkg

`default_nettype wire

// ==== verilog/sar_link_if.sv ====
/*
  Pins between the converter and its host: differential start, burst read
  clock, differential data, echoed clock and the two mode pins.
  Assumes the bench resolves nothing: every pin has exactly one driver.
*/
`timescale 1ns/1ns
`default_nettype none

interface sar_link_if;
  logic conv_start_p;
  logic conv_start_n;
  logic read_clk_p;
  logic read_clk_n;
  logic data_p;
  logic data_n;
  logic echo_p;
  logic echo_n;
  logic snooze;
  logic echo_mode;

  modport dev (
    input  conv_start_p,
    input  conv_start_n,
    input  read_clk_p,
    input  read_clk_n,
    input  snooze,
    input  echo_mode,
    output data_p,
    output data_n,
    output echo_p,
    output echo_n
  );

  modport host (
    output conv_start_p,
    output conv_start_n,
    output read_clk_p,
    output read_clk_n,
    output snooze,
    output echo_mode,
    input  data_p,
    input  data_n,
    input  echo_p,
    input  echo_n
  );
endinterface : sar_link_if

`default_nettype wire

// ==== verilog/two_entry_buffer.sv ====
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes both sides run on one clock; in_ready falls only when both entries hold.
*/
`timescale 1ns/1ns
`default_nettype none

module two_entry_buffer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] spare;
  logic             spare_valid;
  logic             take_out;

  // Output entry may be refilled when empty or being taken
  assign take_out = out_ready || !out_valid;
  assign in_ready = !spare_valid;

  // Output entry
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (take_out) begin
      if (spare_valid) begin
        out_valid <= 1'b1;
        out_data  <= spare;
      end else begin
        out_valid <= in_valid;
        out_data  <= in_data;
      end
    end
  end

  // Spare entry catches a word while the drain stalls
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      spare_valid <= 1'b0;
      spare       <= '0;
    end else if (take_out) begin
      spare_valid <= 1'b0;
    end else if (in_valid && in_ready) begin
      spare_valid <= 1'b1;
      spare       <= in_data;
    end
  end

endmodule : two_entry_buffer

`default_nettype wire

// ==== verilog/sar_conv_host.sv ====
/*
  Host end: issues start pulses, waits for the first bit, bursts the read
  clock from CLOCK and collects the sixteen bits into a two-entry buffer.
  Assumes the user side shares CLOCK; link inputs are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none

`include "sar_readout_cfg.svh"

module sar_conv_host
  import conv_readout_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  sar_link_if.host         link,
  input  wire logic        RUN,
  input  wire logic        SNOOZE,
  input  wire logic        ECHO_MODE,
  output logic [15:0]      RESULT,
  output logic             RESULT_VALID,
  input  wire logic        RESULT_READY,
  output logic             BUSY
);

  host_state_t state;
  logic [7:0]  wait_cnt;
  logic [7:0]  period_cnt;
  logic [2:0]  phase;
  logic [4:0]  bits_sent;
  logic [1:0]  rx_meta;
  logic [1:0]  rx_sync;
  logic        echo_prev;
  logic        take_bit;
  word_t       word;
  logic        cnv;
  logic        rclk;
  logic        snz;
  logic        mode;
  logic        push;
  logic        buf_ready;

  // Data and echo pins, synchronised
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_meta   <= 2'h0;
      rx_sync   <= 2'h0;
      echo_prev <= 1'b0;
    end else begin
      rx_meta   <= {link.echo_p, link.data_p};
      rx_sync   <= rx_meta;
      echo_prev <= rx_sync[1];
    end
  end

  // Bit capture: on each echo edge, or late in each own bit period
  assign take_bit = mode ? (rx_sync[1] != echo_prev) :
                    (state == H_BURST && phase == 3'(2 * `READ_HALF_CYC - 1));

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      word <= '0;
    end else if (take_bit && (state == H_BURST || state == H_TAIL)) begin
      word <= {word[14:0], rx_sync[0]};
    end
  end

  // Least start spacing counter
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      period_cnt <= 8'h00;
    end else if (state == H_IDLE && period_cnt == 8'h00 && RUN && !snz && buf_ready) begin
      period_cnt <= 8'(`CONV_PERIOD_CYC - 1);
    end else if (period_cnt != 8'h00) begin
      period_cnt <= period_cnt - 8'h01;
    end
  end

  // Sequencer
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state     <= H_IDLE;
      wait_cnt  <= 8'h00;
      phase     <= 3'h0;
      bits_sent <= 5'h00;
    end else begin
      case (state)
        H_IDLE: begin
          // Buffer back-pressure stalls the next start
          if (period_cnt == 8'h00 && RUN && !snz && buf_ready) begin
            state    <= H_START;
            wait_cnt <= 8'(`CNV_HIGH_CYC - 1);
          end
        end
        H_START: begin
          if (wait_cnt == 8'h00) begin
            state    <= H_WAIT;
            wait_cnt <= 8'(`FIRST_BIT_READY_CYC - `CNV_HIGH_CYC - 1);
          end else begin
            wait_cnt <= wait_cnt - 8'h01;
          end
        end
        H_WAIT: begin
          // Read clock stays low until the first bit is ready
          if (wait_cnt == 8'h00) begin
            state     <= H_BURST;
            phase     <= 3'h0;
            bits_sent <= 5'h00;
          end else begin
            wait_cnt <= wait_cnt - 8'h01;
          end
        end
        H_BURST: begin
          if (phase == 3'(2 * `READ_HALF_CYC - 1)) begin
            phase     <= 3'h0;
            bits_sent <= bits_sent + 5'h01;
            if (bits_sent == 5'(`RESULT_BITS - 1)) begin
              state    <= H_TAIL;
              wait_cnt <= 8'(`TAIL_CYC - 1);
            end
          end else begin
            phase <= phase + 3'h1;
          end
        end
        H_TAIL: begin
          // Late echo edges of the last bit still arrive here
          if (wait_cnt == 8'h00) begin
            state <= H_PUSH;
          end else begin
            wait_cnt <= wait_cnt - 8'h01;
          end
        end
        H_PUSH: begin
          state <= H_IDLE;
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // Pin drivers: start pulse, burst clock, mode pins changed only in idle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnv  <= 1'b0;
      rclk <= 1'b0;
      snz  <= 1'b0;
      mode <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      cnv  <= (state == H_IDLE && period_cnt == 8'h00 && RUN && !snz && buf_ready) ||
              (state == H_START && wait_cnt != 8'h00);
      rclk <= (state == H_BURST) && (phase < 3'(`READ_HALF_CYC));
      BUSY <= (state != H_IDLE);
      if (state == H_IDLE) begin
        snz  <= SNOOZE;
        mode <= ECHO_MODE;
      end
    end
  end

  assign push = (state == H_PUSH);

  assign link.conv_start_p = cnv;
  assign link.conv_start_n = ~cnv;
  assign link.read_clk_p   = rclk;
  assign link.read_clk_n   = ~rclk;
  assign link.snooze       = snz;
  assign link.echo_mode    = mode;

  // Result queue toward the user
  two_entry_buffer #(
    .WIDTH (`RESULT_BITS)
  ) result_queue (
    .clock     (CLOCK),
    .arst_n    (ARST_N),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (word),
    .out_valid (RESULT_VALID),
    .out_ready (RESULT_READY),
    .out_data  (RESULT)
  );

endmodule : sar_conv_host

`default_nettype wire

// ==== verif/sar_link_sva.sv ====
/*
  Checker of the converter link pins, all sampled on the host CLOCK.
  Assumes the bench instantiates it beside the link interface; read clock comes from CLOCK.
*/
`timescale 1ns/1ns
`default_nettype none

module sar_link_sva (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic conv_start_p,
  input wire logic conv_start_n,
  input wire logic read_clk_p,
  input wire logic read_clk_n,
  input wire logic data_p,
  input wire logic data_n,
  input wire logic echo_p,
  input wire logic echo_n,
  input wire logic snooze,
  input wire logic echo_mode
);
  logic       start_q;
  logic       clk_q;
  logic [7:0] since;
  logic [4:0] rises;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Cycles since the last start edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 1'b0;
      since   <= 8'hff;
    end else begin
      start_q <= conv_start_p;
      if (conv_start_p && !start_q) begin
        since <= 8'h00;
      end else if (since != 8'hff) begin
        since <= since + 8'h01;
      end
    end
  end

  // Read clock rising edges within the current burst
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clk_q <= 1'b0;
      rises <= 5'h00;
    end else begin
      clk_q <= read_clk_p;
      if (conv_start_p && !start_q) begin
        rises <= 5'h00;
      end else if (read_clk_p && !clk_q) begin
        rises <= rises + 5'h01;
      end
    end
  end

  property p_start_legs;
    conv_start_n == !conv_start_p;
  endproperty
  a_start_legs: assert property (p_start_legs) else $error("start legs not complementary");

  property p_pin_legs;
    (data_n == !data_p) && (read_clk_n == !read_clk_p) && (echo_n == !echo_p);
  endproperty
  a_pin_legs: assert property (p_pin_legs) else $error("link legs not complementary");

  property p_start_width;
    $rose(conv_start_p) |=> conv_start_p ##1 !conv_start_p;
  endproperty
  a_start_width: assert property (p_start_width) else $error("start pulse width wrong");

  property p_start_spacing;
    $rose(conv_start_p) |-> since >= 8'd24;
  endproperty
  a_start_spacing: assert property (p_start_spacing) else $error("starts too close");

  property p_first_bit_wait;
    $rose(read_clk_p) |-> since >= 8'd23;
  endproperty
  a_first_bit_wait: assert property (p_first_bit_wait) else $error("burst before first bit");

  property p_burst_count;
    $rose(conv_start_p) |-> (rises == 5'd0 || rises == 5'd16);
  endproperty
  a_burst_count: assert property (p_burst_count) else $error("burst not sixteen edges");

  property p_burst_stop;
    $rose(read_clk_p) |-> rises < 5'd16;
  endproperty
  a_burst_stop: assert property (p_burst_stop) else $error("read clock after last bit");

  property p_clk_high;
    $rose(read_clk_p) |-> read_clk_p [*3] ##1 !read_clk_p;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("read clock high phase wrong");

  property p_clk_low;
    $fell(read_clk_p) && rises < 5'd16 |-> !read_clk_p [*3] ##1 read_clk_p;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("read clock low phase wrong");

  property p_data_on_edge;
    $changed(data_p) |-> $rose(read_clk_p);
  endproperty
  a_data_on_edge: assert property (p_data_on_edge) else $error("data moved off clock edge");

  property p_echo_on_edge;
    $changed(echo_p) |-> $rose(read_clk_p) && echo_mode;
  endproperty
  a_echo_on_edge: assert property (p_echo_on_edge) else $error("echo moved off clock edge");

  property p_snooze_quiet;
    $changed(snooze) |-> !conv_start_p;
  endproperty
  a_snooze_quiet: assert property (p_snooze_quiet) else $error("snooze changed with start");
endmodule : sar_link_sva

`default_nettype wire

// ==== verif/testbench.sv ====
/*
  Self-checking bench: host and converter joined by the link, table of conversions,
  then full buffer, snooze and mid-run reset.
  Assumes the design files and package are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import conv_readout_pkg::*;
  typedef struct {word_t sample; logic lvds; logic echo; word_t want;} row_t;

  logic  clock;
  logic  arst_n;
  logic  run;
  logic  snooze;
  logic  echo_mode;
  logic  lvds;
  logic  ready;
  logic  dev_busy;
  logic  host_busy;
  logic  valid;
  word_t sample;
  word_t dev_result;
  word_t host_result;
  int    bad_count = 0;
  int    checks_done = 0;
  int    conv_count = 0;
  int    base;
  row_t  rows [7] = '{
    '{16'h7fff, 1'b1, 1'b0, 16'h7fff},
    '{16'h0000, 1'b1, 1'b0, 16'h0000},
    '{16'hffff, 1'b0, 1'b0, 16'hffff},
    '{16'h8000, 1'b0, 1'b0, 16'h8000},
    '{16'h0001, 1'b1, 1'b1, 16'h0001},
    '{16'h8001, 1'b0, 1'b1, 16'h8001},
    '{16'h5ac3, 1'b1, 1'b1, 16'h5ac3}};

  sar_link_if link ();
  sar_conv_dev sar_conv_dev_i (.CLOCK(clock), .ARST_N(arst_n), .link(link), .SAMPLE(sample),
    .CNV_LVDS(lvds), .BUSY(dev_busy), .RESULT(dev_result));
  sar_conv_host sar_conv_host_i (.CLOCK(clock), .ARST_N(arst_n), .link(link), .RUN(run),
    .SNOOZE(snooze), .ECHO_MODE(echo_mode), .RESULT(host_result), .RESULT_VALID(valid),
    .RESULT_READY(ready), .BUSY(host_busy));
  sar_link_sva sar_link_sva_i (.clock(clock), .arst_n(arst_n),
    .conv_start_p(link.conv_start_p), .conv_start_n(link.conv_start_n),
    .read_clk_p(link.read_clk_p), .read_clk_n(link.read_clk_n), .data_p(link.data_p),
    .data_n(link.data_n), .echo_p(link.echo_p), .echo_n(link.echo_n),
    .snooze(link.snooze), .echo_mode(link.echo_mode));

  // Clock at 125 MHz
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Count accepted conversions
  always @(posedge dev_busy) conv_count++;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, want, seen);
    end
  endtask : check

  // Wait on host busy (0), converter busy (1) or result valid (2)
  task automatic wait_sig(input int which, input logic level);
    int n;
    n = 0;
    while ((which == 0 ? host_busy : which == 1 ? dev_busy : valid) !== level && n < 400) begin
      @(negedge clock);
      n++;
    end
    if (n == 400) begin
      bad_count++;
      $display("BAD wait %0d expected %b seen timeout", which, level);
    end
  endtask : wait_sig

  task automatic take(input word_t want);
    check("valid", valid, 1'b1);
    check("host_result", host_result, want);
    ready = 1'b1;
    @(negedge clock);
    ready = 1'b0;
    @(negedge clock);
  endtask : take

  task automatic run_row(input row_t r);
    sample = r.sample;
    lvds = r.lvds;
    echo_mode = r.echo;
    repeat (4) @(negedge clock);
    run = 1'b1;
    wait_sig(0, 1'b1);
    run = 1'b0;
    wait_sig(2, 1'b1);
    check("dev_result", dev_result, r.want);
    take(r.want);
    check("valid_after", valid, 1'b0);
    wait_sig(0, 1'b0);
  endtask : run_row

  task automatic check_reset();
    check("host_valid", valid, 1'b0);
    check("host_busy", host_busy, 1'b0);
    check("host_result", host_result, 16'h0000);
    check("dev_busy", dev_busy, 1'b0);
    check("dev_result", dev_result, 16'h0000);
    check("read_clk", {link.read_clk_p, link.read_clk_n}, 2'b01);
    check("start", {link.conv_start_p, link.conv_start_n}, 2'b01);
    check("data", {link.data_p, link.data_n, link.echo_p, link.echo_n}, 4'b0101);
  endtask : check_reset

  task automatic test_done();
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    test_done();
  end

  // Main sequence, inputs change on the falling edge
  initial begin
    arst_n = 1'b0;
    run = 1'b0;
    snooze = 1'b0;
    echo_mode = 1'b0;
    lvds = 1'b1;
    ready = 1'b0;
    sample = 16'h0000;
    repeat (6) @(negedge clock);
    check_reset();
    arst_n = 1'b1;
    repeat (8) @(negedge clock);
    foreach (rows[i]) run_row(rows[i]);
    // Full buffer: two words held, no third start
    base = conv_count;
    sample = 16'h0a5a;
    run = 1'b1;
    wait_sig(1, 1'b1);
    wait_sig(1, 1'b0);
    sample = 16'hc3c3;
    wait_sig(1, 1'b1);
    wait_sig(1, 1'b0);
    sample = 16'h1111;
    repeat (600) @(negedge clock);
    check("conversions", 16'(conv_count - base), 16'h0002);
    run = 1'b0;
    wait_sig(0, 1'b0);
    take(16'h0a5a);
    take(16'hc3c3);
    check("valid_drained", valid, 1'b0);
    // Snooze: host issues no starts
    snooze = 1'b1;
    echo_mode = 1'b0;
    repeat (4) @(negedge clock);
    base = conv_count;
    run = 1'b1;
    repeat (300) @(negedge clock);
    run = 1'b0;
    check("snoozed_convs", 16'(conv_count - base), 16'h0000);
    check("snoozed_result", dev_result, 16'hc3c3);
    wait_sig(0, 1'b0);
    ready = 1'b1;
    repeat (4) @(negedge clock);
    ready = 1'b0;
    snooze = 1'b0;
    repeat (4) @(negedge clock);
    run_row('{16'h4321, 1'b1, 1'b0, 16'h4321});
    // Reset in the middle of a burst
    sample = 16'h5a5a;
    run = 1'b1;
    wait_sig(0, 1'b1);
    repeat (40) @(negedge clock);
    arst_n = 1'b0;
    run = 1'b0;
    @(negedge clock);
    check_reset();
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    repeat (8) @(negedge clock);
    check_reset();
    run_row('{16'h2468, 1'b0, 1'b0, 16'h2468});
    test_done();
  end
endmodule : testbench

`default_nettype wire
